// ---- rtl/umpc_pkg.sv ----
// Package for the nine-bit multiprocessor control block.
// Assumes a 32-bit classic Wishbone slave port and one clock.
`default_nettype none
package umpc_pkg;
    // ==========================================================
    // Register map (byte addresses, one word per register)
    localparam logic [11:0] ADDR_CTRL0     = 12'hf42;
    localparam logic [11:0] ADDR_CTRL1_IDX = 12'hf43;
    localparam logic [13:0] OFS_CTRL1      = 14'h3d0c;  // Index times four
    localparam logic [13:0] OFS_CTRL0      = 14'h3d08;  // Index times four
    localparam logic [13:0] OFS_ADDRCMP    = 14'h3d10;
    localparam logic [13:0] OFS_IRQSTAT    = 14'h3d14;
    localparam logic [13:0] OFS_IRQMASK    = 14'h3d18;
    localparam logic [13:0] OFS_RXSTAT     = 14'h3d1c;
    // ==========================================================
    // Field positions
    localparam int BIT_MODE_HI  = 7;
    localparam int BIT_NINE_EN  = 6;
    localparam int BIT_MODE_LO  = 5;
    localparam int BIT_TX_NINTH = 4;
    localparam int BIT_DE_POL   = 3;
    localparam int BIT_PAR_ON   = 4;
    localparam int PAGE_LO      = 8;  // Page select in ctrl1 word bits 10:8
    localparam int IRQ_RXHIT    = 0;
    localparam int IRQ_RXDROP   = 1;
    // ==========================================================
    // Reset values and page code
    localparam logic [7:0] RST_CTRL  = 8'h00;
    localparam logic [2:0] RST_PAGE  = 3'h0;
    localparam logic [2:0] PAGE_MP   = 3'h0;
    localparam logic [7:0] RST_CMP   = 8'h00;
    localparam logic [1:0] RST_IRQ   = 2'h0;
    // Filter modes
    typedef enum logic [1:0] {
        FLT_ALL      = 2'b00,
        FLT_ADDR     = 2'b01,
        FLT_MATCH_IN = 2'b10,
        FLT_DATA_ONLY= 2'b11
    } umpc_mode_t;
    // Received character as it leaves the receiver
    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
    } umpc_char_t;
endpackage : umpc_pkg
`default_nettype wire

// ---- rtl/umpc_filter.sv ----
// Receive interrupt filter for nine-bit multiprocessor framing.
// Assumes one received character per valid pulse, synchronous inputs.
`default_nettype none
module umpc_filter (
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    input  wire logic                   nineOn,
    input  wire umpc_pkg::umpc_mode_t   mode,
    input  wire logic [7:0]             cmpValue,
    input  wire logic                   rxValid,
    input  wire umpc_pkg::umpc_char_t   rxChar,
    output logic                        hit,
    output logic                        drop,
    output logic                        matched
);
    // ==========================================================
    // Byte classification
    wire isAddr   = nineOn & rxChar.ninth;
    wire isData   = ~isAddr;
    wire addrHit  = isAddr & (rxChar.data == cmpValue);
    wire want;
    assign want = !nineOn ? 1'b1 :
                  (mode == umpc_pkg::FLT_ALL)      ? 1'b1 :
                  (mode == umpc_pkg::FLT_ADDR)     ? isAddr :
                  (mode == umpc_pkg::FLT_MATCH_IN) ? (isAddr ? addrHit : matched) :
                  (isData & matched);

    // Match state follows the latest address byte
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            matched <= 1'b0;
            hit     <= 1'b0;
            drop    <= 1'b0;
        end else begin
            if (rxValid && isAddr) begin
                matched <= addrHit;
            end
            hit  <= rxValid & want;
            drop <= rxValid & ~want;
        end
    end
endmodule : umpc_filter
`default_nettype wire

// ---- rtl/umpc_ctrl.sv ----
// Nine-bit multiprocessor control page with Wishbone slave and interrupt.
// Assumes classic Wishbone, 32-bit data, one clock, synchronous reset.
//
// Register access over Wishbone was chosen for this implementation.
`default_nettype none
// Notes on behaviour
// - One control address holds several pages; page 000 is the multiprocessor page.
// - Filter mode 00 interrupts on every received byte.
// - Filter mode 01 interrupts only on address bytes.
// - Mode 10 interrupts on matching address and following data until mismatch.
// - Mode 11 interrupts only on data after a matching address.
// - Bit 6 switches nine-bit framing on or off.
// - In nine-bit mode bit 4 is sent as ninth bit.
// - Driver enable active high when bit 3 zero, low when one.
// - Nine-bit mode overrides parity for the ninth bit.
module umpc_ctrl (
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    // Wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [13:0]          wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    output logic                      wb_err_o,
    // Receiver side
    input  wire logic                 rxValid,
    input  wire umpc_pkg::umpc_char_t rxChar,
    // Transmitter side, receive request and interrupt
    input  wire logic                 txActive,
    output logic                      nineBitOn,
    output logic                      parityBitOn,
    output logic                      txNinthBit,
    output logic                      driver_enable_out,
    output logic                      rxIrqReq,
    output logic                      irq
);
    // ==========================================================
    // Register state
    logic [7:0] ctrl0;
    logic [7:0] mpCtrl;
    logic [7:0] otherPage [1:7];
    logic [2:0] register_page_select;
    logic [7:0] cmpValue;
    logic [1:0] irqStat;
    logic [1:0] irqMask;
    logic       hit;
    logic       drop;
    logic       matched;

    // ==========================================================
    // Field views
    wire nine_bit_mode_enable = mpCtrl[umpc_pkg::BIT_NINE_EN];
    wire ninth_bit_tx_value   = mpCtrl[umpc_pkg::BIT_TX_NINTH];
    wire driver_en_polarity   = mpCtrl[umpc_pkg::BIT_DE_POL];
    wire parity_on            = ctrl0[umpc_pkg::BIT_PAR_ON];
    wire [1:0] addr_filter_irq_mode = {mpCtrl[umpc_pkg::BIT_MODE_HI], mpCtrl[umpc_pkg::BIT_MODE_LO]};

    // ==========================================================
    // Bus decode
    wire req       = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire selCtrl0  = wb_adr_i == umpc_pkg::OFS_CTRL0;
    wire selCtrl1  = wb_adr_i == umpc_pkg::OFS_CTRL1;
    wire selCmp    = wb_adr_i == umpc_pkg::OFS_ADDRCMP;
    wire selStat   = wb_adr_i == umpc_pkg::OFS_IRQSTAT;
    wire selMask   = wb_adr_i == umpc_pkg::OFS_IRQMASK;
    wire selRx     = wb_adr_i == umpc_pkg::OFS_RXSTAT;
    wire mapped    = selCtrl0 | selCtrl1 | selCmp | selStat | selMask | selRx;
    wire wrLane0   = req & mapped & wb_we_i & wb_sel_i[0];
    wire wrLane1   = req & mapped & wb_we_i & wb_sel_i[1];
    wire pageIsMp  = register_page_select == umpc_pkg::PAGE_MP;
    wire [7:0] pageRead = pageIsMp ? mpCtrl : otherPage[register_page_select];
    wire [31:0] rdMux =
        selCtrl0 ? {24'h000000, ctrl0} :
        selCtrl1 ? {21'h000000, register_page_select, pageRead} :
        selCmp   ? {24'h000000, cmpValue} :
        selStat  ? {30'h00000000, irqStat} :
        selMask  ? {30'h00000000, irqMask} :
        selRx    ? {30'h00000000, matched, txActive} :
        32'h00000000;
    wire [1:0] clrBits = (wrLane0 & selStat) ? wb_dat_i[1:0] : 2'h0;
    wire [1:0] setBits;
    assign setBits[umpc_pkg::IRQ_RXHIT]  = hit;
    assign setBits[umpc_pkg::IRQ_RXDROP] = drop;

    // ==========================================================
    // Bus answer, one cycle after request
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req & mapped;
            wb_err_o <= req & ~mapped;
            wb_dat_o <= (req & mapped & ~wb_we_i) ? rdMux : 32'h00000000;
        end
    end

    // Control register writes
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ctrl0                <= umpc_pkg::RST_CTRL;
            mpCtrl               <= umpc_pkg::RST_CTRL;
            register_page_select <= umpc_pkg::RST_PAGE;
            cmpValue             <= umpc_pkg::RST_CMP;
            irqMask              <= umpc_pkg::RST_IRQ;
            for (int i = 1; i < 8; i++) begin
                otherPage[i] <= umpc_pkg::RST_CTRL;
            end
        end else begin
            if (wrLane0 & selCtrl0) begin
                ctrl0 <= wb_dat_i[7:0];
            end
            if (wrLane1 & selCtrl1) begin
                register_page_select <= wb_dat_i[10:8];
            end
            if (wrLane0 & selCtrl1) begin
                if (pageIsMp) begin
                    mpCtrl <= wb_dat_i[7:0];
                end else begin
                    otherPage[register_page_select] <= wb_dat_i[7:0];
                end
            end
            if (wrLane0 & selCmp) begin
                cmpValue <= wb_dat_i[7:0];
            end
            if (wrLane0 & selMask) begin
                irqMask <= wb_dat_i[1:0];
            end
        end
    end

    // Sticky status, set wins over clear
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            irqStat <= umpc_pkg::RST_IRQ;
        end else begin
            irqStat <= (irqStat & ~clrBits) | setBits;
        end
    end

    // ==========================================================
    // Receive filter
    umpc_filter u_filter (
        .mclk     (mclk),
        .rstn     (rstn),
        .nineOn   (nine_bit_mode_enable),
        .mode     (umpc_pkg::umpc_mode_t'(addr_filter_irq_mode)),
        .cmpValue (cmpValue),
        .rxValid  (rxValid),
        .rxChar   (rxChar),
        .hit      (hit),
        .drop     (drop),
        .matched  (matched)
    );

    // ==========================================================
    // Outputs to the framer, receive request and interrupt
    // framing switch
    assign nineBitOn   = nine_bit_mode_enable;
    assign parityBitOn = parity_on & ~nine_bit_mode_enable;
    assign txNinthBit  = nine_bit_mode_enable & ninth_bit_tx_value;
    assign driver_enable_out = txActive ^ driver_en_polarity;
    assign rxIrqReq    = hit;
    assign irq         = |(irqStat & irqMask);
endmodule : umpc_ctrl
`default_nettype wire

// ---- dv/umpc_checker.sv ----
// Checker: port relations of the nine-bit control block.
// Assumes one clock mclk and a synchronous active-low rstn.
`default_nettype none
module umpc_checker (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        rxValid,
    input wire logic        txActive,
    input wire logic        nineBitOn,
    input wire logic        parityBitOn,
    input wire logic        txNinthBit,
    input wire logic        driver_enable_out,
    input wire logic        rxIrqReq,
    input wire logic        irq
);
    // ==========================================
    // Bus, framing and receive relations
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
        else $error("bus request not answered");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
    a_ninth_gate: assert property (txNinthBit |-> nineBitOn) else $error("ninth bit without mode");
    a_parity_over: assert property (nineBitOn |-> !parityBitOn) else $error("parity kept in mode");
    a_de_steady: assert property (!wb_ack_o |-> $stable(driver_enable_out ^ txActive))
        else $error("driver polarity moved");
    a_irq_cause: assert property (rxIrqReq |-> $past(rxValid)) else $error("request without char");
    a_plain_pass: assert property (rxValid && !nineBitOn |=> rxIrqReq) else $error("plain char dropped");
    a_irq_source: assert property ($rose(irq) |-> wb_ack_o || $past(rxValid, 2))
        else $error("interrupt without cause");
endmodule : umpc_checker
bind umpc_ctrl umpc_checker CHK (.mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .rxValid(rxValid), .txActive(txActive),
    .nineBitOn(nineBitOn), .parityBitOn(parityBitOn), .txNinthBit(txNinthBit),
    .driver_enable_out(driver_enable_out), .rxIrqReq(rxIrqReq), .irq(irq));
`default_nettype wire

// ---- dv/umpc_node_model.sv ----
// Far node: hands received characters to the block.
// Assumes the bench clock; one character per call.
`default_nettype none
module umpc_node_model (
    input  wire logic            mclk,
    output umpc_pkg::umpc_char_t rxChar,
    output logic                 rxValid
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle state
    initial begin
        rxValid = 1'b0;
        rxChar  = '0;
    end
    task automatic send(input logic nin, input logic [7:0] dat);
        @(posedge mclk);
        rxValid <= 1'b1;
        rxChar  <= {nin, dat};
        @(posedge mclk);
        rxValid <= 1'b0;
        rxChar  <= ~{nin, dat};  // Driven to the complement: no stale value
    endtask : send
endmodule : umpc_node_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// Bench: Wishbone tasks, far node model and the block.
// Assumes the bound checker and the package offsets.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [13:0] C1 = umpc_pkg::OFS_CTRL1;
    logic        mclk = 1'b0;
    logic        rstn, cyc, stb, we, txActive, ack, err, rxValid, nineOn, parOn, ninth, drvEn, rxReq, irq;
    logic [13:0] adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [7:0]  vals [4] = '{8'h00, 8'h10, 8'h48, 8'h58};
    logic [3:0]  pass [4] = '{4'b1111, 4'b1010, 4'b1100, 4'b0100};
    umpc_pkg::umpc_char_t rxChar;
    int          mismatches = 0, total_checks = 0, cycles = 0;
    umpc_ctrl DUT (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .rxValid(rxValid),
        .rxChar(rxChar), .txActive(txActive), .nineBitOn(nineOn), .parityBitOn(parOn), .txNinthBit(ninth),
        .driver_enable_out(drvEn), .rxIrqReq(rxReq), .irq(irq));
    umpc_node_model NODE (.mclk(mclk), .rxChar(rxChar), .rxValid(rxValid));
    // ==========================================
    // Clock, timeout and shared tasks
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 3000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge mclk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= s;
        // Wait for the answer; only the bench timeout ends a hang
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1 && err !== 1'b1);
        q = err ? 32'hdead : rdat;
        chk("answer", 32'h1, {31'h0, ack ^ err});
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : bus
    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask : settle
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    // Main sequence
    initial begin
        {rstn, cyc, stb, we, txActive, adr, sel, wdat} = '0;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        bus(0, C1, 0, 4'hf);
        chk("ctrl1 reset", 32'h0, q);
        chk("de idle", {31'h0, txActive}, {31'h0, drvEn});
        bus(1, C1, 32'h048, 4'h3);
        bus(1, C1, 32'h100, 4'h2);
        bus(1, C1, 32'h0a5, 4'h1);
        bus(0, C1, 0, 4'hf);
        chk("page one", 32'h1a5, q);
        chk("page zero kept", 32'h1, {31'h0, nineOn});
        bus(1, C1, 32'h000, 4'h2);
        bus(0, C1, 0, 4'hf);
        chk("page zero", 32'h048, q);
        $display("test paging done");
        bus(1, umpc_pkg::OFS_CTRL0, 32'h10, 4'h1);
        foreach (vals[i]) begin
            bus(1, C1, {24'h0, vals[i]}, 4'h1);
            for (int t = 0; t < 2; t++) begin
                @(posedge mclk);
                txActive <= t[0];
                #1;
                chk("nine on", {31'h0, vals[i][6]}, {31'h0, nineOn});
                chk("ninth", {31'h0, vals[i][6] & vals[i][4]}, {31'h0, ninth});
                chk("parity", {31'h0, !vals[i][6]}, {31'h0, parOn});
                chk("de", {31'h0, t[0] ^ vals[i][3]}, {31'h0, drvEn});
            end
        end
        $display("test controls done");
        bus(1, umpc_pkg::OFS_ADDRCMP, 32'h5a, 4'h1);
        bus(1, umpc_pkg::OFS_IRQMASK, 32'h1, 4'h1);
        for (int m = 0; m < 4; m++) begin
            bus(1, C1, {24'h0, m[1], 1'b1, m[0], 5'h0}, 4'h1);
            for (int k = 0; k < 4; k++) begin
                NODE.send(!k[0], k[1] ? 8'h33 : 8'h5a);
                #1;
                chk("rx request", {31'h0, pass[m][3-k]}, {31'h0, rxReq});
            end
        end
        NODE.send(1'b1, 8'h5a);
        #1;
        chk("addr no request", 32'h0, {31'h0, rxReq});
        bus(0, umpc_pkg::OFS_RXSTAT, 0, 4'hf);
        chk("rx status", 32'h3, q);
        bus(0, umpc_pkg::OFS_IRQSTAT, 0, 4'hf);
        chk("stat both", 32'h3, q);
        $display("test filter done");
        settle();
        chk("irq set", 32'h1, {31'h0, irq});
        bus(1, umpc_pkg::OFS_IRQMASK, 32'h0, 4'h1);
        settle();
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1, umpc_pkg::OFS_IRQSTAT, 32'h3, 4'h1);
        bus(0, umpc_pkg::OFS_IRQSTAT, 0, 4'hf);
        chk("stat clear", 32'h0, q);
        bus(1, C1, 32'h0, 4'h1);
        NODE.send(1'b0, 8'h77);
        #1;
        chk("plain rx", 32'h1, {31'h0, rxReq});
        bus(0, 14'h0000, 0, 4'hf);
        chk("unmapped", 32'hdead, q);
        $display("test irq and refusal done");
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
